// ==== tlr_map.vh ====
`ifndef TLR_MAP_VH
`define TLR_MAP_VH
// Register indices on the plain port (byte address = index * 4)
`define TLR_ADDR_W 4
`define TLR_REG_CTRL 4'h0
`define TLR_REG_BASE 4'h1
`define TLR_REG_G0L0 4'h2
`define TLR_REG_G0L1 4'h3
`define TLR_REG_G1L0 4'h4
`define TLR_REG_G1L1 4'h5
`define TLR_REG_STAT 4'h6
// Control register fields
`define TLR_CTRL_EN0 0
`define TLR_CTRL_EN1 1
`define TLR_CTRL_LDOK 2
`define TLR_CTRL_LIST0 3
`define TLR_CTRL_LIST1 4
// Status fields, write one to clear: {ro, te1, te0, done1, done0}
`define TLR_ST_DONE0 0
`define TLR_ST_DONE1 1
`define TLR_ST_TE0 2
`define TLR_ST_TE1 3
`define TLR_ST_RO 4
`define TLR_ST_W 5
// Entry and window sizes
`define TLR_VAL_W 16
`define TLR_EOL 16'h0000
`define TLR_WIN_W 8
`define TLR_OFS_W 8
`define TLR_ADR_W 24
// Generator states
`define TLR_S_IDLE 3'h0
`define TLR_S_REQ 3'h1
`define TLR_S_WAIT 3'h2
`define TLR_S_ARM 3'h3
`define TLR_S_HALT 3'h4
`endif

// ==== tlr_sync.v ====
`timescale 1ns/10ps
`default_nettype none
module tlr_sync (
  // Clock and raw reset
  input wire clk,
  input wire arst_n,
  // Released reset
  output wire rst_n
);
  reg s1_reg;
  reg s2_reg;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= 1'b1;
      s2_reg <= s1_reg;
    end
  end
  assign rst_n = s2_reg;
endmodule
`default_nettype wire

// ==== tlr_gen.v ====
`timescale 1ns/10ps
`default_nettype none
`include "tlr_map.vh"
module tlr_gen (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire enable,
  input wire reload,
  input wire [`TLR_WIN_W-1:0] list_offset,
  // Memory fetch
  output reg fetch_req,
  output wire [`TLR_WIN_W-1:0] fetch_addr,
  input wire fetch_ack,
  input wire [`TLR_VAL_W-1:0] fetch_data,
  // Events
  output reg trigger,
  output reg done_set,
  output reg te_set
);
  reg [2:0] state_reg;
  reg [`TLR_VAL_W-1:0] cnt_reg;
  reg [`TLR_VAL_W-1:0] cur_reg;
  reg [`TLR_VAL_W-1:0] prev_reg;
  reg [`TLR_WIN_W-1:0] idx_reg;
  reg first_reg;
  // Byte offset in the window wraps, so fetches never leave it
  assign fetch_addr = list_offset + {idx_reg[`TLR_WIN_W-2:0], 1'b0}; // [RL7]
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= `TLR_S_IDLE;
      cnt_reg <= 16'h0000;
      cur_reg <= 16'h0000;
      prev_reg <= 16'h0000;
      idx_reg <= 8'h00;
      first_reg <= 1'b0;
      fetch_req <= 1'b0;
      trigger <= 1'b0;
      done_set <= 1'b0;
      te_set <= 1'b0;
    end
    else
    begin
      trigger <= 1'b0;
      done_set <= 1'b0;
      te_set <= 1'b0;
      if (cnt_reg != 16'hffff)
        cnt_reg <= cnt_reg + 16'h0001;
      if (!enable)
      begin
        state_reg <= `TLR_S_IDLE;
        fetch_req <= 1'b0;
      end
      else if (reload)
      begin
        // Delays count from this reload; first entry of the chosen list
        cnt_reg <= 16'h0000; // [RL3]
        idx_reg <= 8'h00; // [RL10]
        first_reg <= 1'b1;
        fetch_req <= 1'b1;
        state_reg <= `TLR_S_WAIT;
      end
      else
      begin
        case (state_reg)
          `TLR_S_WAIT:
          begin
            if (fetch_ack)
            begin
              fetch_req <= 1'b0;
              if (fetch_data == `TLR_EOL)
              begin
                done_set <= 1'b1; // [RL4] [RL19]
                state_reg <= `TLR_S_HALT;
              end
              else if ((!first_reg && fetch_data < prev_reg) || fetch_data < cnt_reg)
              begin
                te_set <= 1'b1; // [RL6]
                state_reg <= `TLR_S_HALT;
              end
              else
              begin
                cur_reg <= fetch_data;
                prev_reg <= fetch_data;
                first_reg <= 1'b0;
                idx_reg <= idx_reg + 8'h01;
                state_reg <= `TLR_S_ARM;
              end
            end
          end
          `TLR_S_ARM:
          begin
            if (cnt_reg == cur_reg)
            begin
              trigger <= 1'b1; // [RL18]
              fetch_req <= 1'b1;
              state_reg <= `TLR_S_WAIT;
            end
          end
          `TLR_S_REQ:
            state_reg <= `TLR_S_WAIT;
          `TLR_S_HALT:
            state_reg <= `TLR_S_HALT;
          default:
            state_reg <= `TLR_S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== tlr_top.v ====
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tlr_map.vh"
// Operation
// [RL1] List base pointer cannot be written while either generator is enabled.
// [RL2] A generator's list offsets cannot be written while it is enabled.
// [RL3] Each entry is a 16-bit delay in clock cycles after reload.
// [RL4] A zero entry ends the list; no further triggers from it.
// [RL5] Software sorts each list in ascending order.
// [RL6] Falling or already-passed entry sets timing error and halts until reload.
// [RL7] Fetches stay within 256 bytes from the base pointer. Here the base pointer's low 8 bits are dropped.
// [RL8] Each generator owns two lists and alternates between them.
// [RL9] Software sets load-ok after refilling the alternate list.
// [RL10] Reload with load-ok switches list and fetches its first entry.
// [RL11] Every reload clears load-ok; here a load-ok set written in the same cycle wins.
// [RL12] Active-list bit shows list in use; writable only when disabled.
// [RL13] Reload without load-ok sets overrun; both keep their current list. Here overrun is set only while a generator is enabled.
// [RL14] Load-ok is exported as a global output.
// [RL15] Equal offsets still toggle the active-list bit at each swap.
// [RL16] Software updates a shared list only between done and reload.
// [RL17] Reload with async qualifier behaves exactly as a normal reload.
// [RL18] Trigger fires when counter equals entry, then next entry fetched.
// [RL19] End marker in the active list sets the done flag.
module tlr_top (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Register port
  input wire [`TLR_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Reload inputs
  input wire reload,
  input wire async_reload_qualifier,
  // Memory read port, one request at a time
  output reg mem_req,
  output reg [`TLR_ADR_W-1:0] mem_addr,
  input wire mem_ack,
  input wire [`TLR_VAL_W-1:0] mem_data,
  // Events and flags
  output reg gen0_trigger,
  output reg gen1_trigger,
  output reg load_ok,
  output reg gen0_done_flag,
  output reg gen1_done_flag,
  output reg timing_error_flag,
  output reg reload_overrun_flag
);
  wire rst_n;
  reg en0_reg;
  reg en1_reg;
  reg ldok_reg;
  reg list0_reg;
  reg list1_reg;
  reg [`TLR_ADR_W-1:0] base_reg;
  reg [`TLR_OFS_W-1:0] g0l0_reg;
  reg [`TLR_OFS_W-1:0] g0l1_reg;
  reg [`TLR_OFS_W-1:0] g1l0_reg;
  reg [`TLR_OFS_W-1:0] g1l1_reg;
  reg [`TLR_ST_W-1:0] stat_reg;
  reg [`TLR_ST_W-1:0] stat_next;
  reg owner_reg;
  reg busy_reg;
  wire req0;
  wire req1;
  wire [`TLR_WIN_W-1:0] addr0;
  wire [`TLR_WIN_W-1:0] addr1;
  wire trig0;
  wire trig1;
  wire done0;
  wire done1;
  wire te0;
  wire te1;
  wire rl_evt;
  wire sel0;
  wire sel1;
  wire wr_ctrl;
  wire wr_base;
  wire wr_g0l0;
  wire wr_g0l1;
  wire wr_g1l0;
  wire wr_g1l1;
  wire wr_stat;
  wire swap_evt;
  wire ro_evt;
  wire ack0;
  wire ack1;
  wire [`TLR_OFS_W-1:0] ofs0;
  wire [`TLR_OFS_W-1:0] ofs1;
  reg [31:0] rdata_next;
  tlr_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .rst_n(rst_n)
  );
  // Qualifier does not alter the response; any reload is the same event
  assign rl_evt = reload | (reload & async_reload_qualifier); // [RL17]
  assign wr_ctrl = reg_wr && reg_addr == `TLR_REG_CTRL;
  assign wr_base = reg_wr && reg_addr == `TLR_REG_BASE && !en0_reg && !en1_reg; // [RL1]
  assign wr_g0l0 = reg_wr && reg_addr == `TLR_REG_G0L0 && !en0_reg; // [RL2]
  assign wr_g0l1 = reg_wr && reg_addr == `TLR_REG_G0L1 && !en0_reg; // [RL2]
  assign wr_g1l0 = reg_wr && reg_addr == `TLR_REG_G1L0 && !en1_reg; // [RL2]
  assign wr_g1l1 = reg_wr && reg_addr == `TLR_REG_G1L1 && !en1_reg; // [RL2]
  assign wr_stat = reg_wr && reg_addr == `TLR_REG_STAT;
  assign swap_evt = rl_evt && ldok_reg;
  assign ro_evt = rl_evt && !ldok_reg && (en0_reg || en1_reg); // [RL13]
  // Acknowledge goes only to the generator that owns the fetch
  assign ack0 = mem_ack && busy_reg && !owner_reg;
  assign ack1 = mem_ack && busy_reg && owner_reg;
  assign ofs0 = list0_reg ? g0l1_reg : g0l0_reg; // [RL8]
  assign ofs1 = list1_reg ? g1l1_reg : g1l0_reg; // [RL8]
  // List selected for the coming period: toggled on a load-ok reload
  assign sel0 = (rl_evt && ldok_reg) ? ~list0_reg : list0_reg;
  assign sel1 = (rl_evt && ldok_reg) ? ~list1_reg : list1_reg;
  tlr_gen u_gen0 (
    .clk(clk),
    .rst_n(rst_n),
    .enable(en0_reg),
    .reload(rl_evt),
    .list_offset(ofs0),
    .fetch_req(req0),
    .fetch_addr(addr0),
    .fetch_ack(ack0),
    .fetch_data(mem_data),
    .trigger(trig0),
    .done_set(done0),
    .te_set(te0)
  );
  tlr_gen u_gen1 (
    .clk(clk),
    .rst_n(rst_n),
    .enable(en1_reg),
    .reload(rl_evt),
    .list_offset(ofs1),
    .fetch_req(req1),
    .fetch_addr(addr1),
    .fetch_ack(ack1),
    .fetch_data(mem_data),
    .trigger(trig1),
    .done_set(done1),
    .te_set(te1)
  );
  // Enables, base pointer and list offsets
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en0_reg <= 1'b0;
      en1_reg <= 1'b0;
      base_reg <= 24'h000000;
      g0l0_reg <= 8'h00;
      g0l1_reg <= 8'h00;
      g1l0_reg <= 8'h00;
      g1l1_reg <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
      begin
        en0_reg <= reg_wdata[`TLR_CTRL_EN0];
        en1_reg <= reg_wdata[`TLR_CTRL_EN1];
      end
      if (wr_base)
        base_reg <= reg_wdata[`TLR_ADR_W-1:0];
      if (wr_g0l0)
        g0l0_reg <= reg_wdata[`TLR_OFS_W-1:0];
      if (wr_g0l1)
        g0l1_reg <= reg_wdata[`TLR_OFS_W-1:0];
      if (wr_g1l0)
        g1l0_reg <= reg_wdata[`TLR_OFS_W-1:0];
      if (wr_g1l1)
        g1l1_reg <= reg_wdata[`TLR_OFS_W-1:0];
    end
  end
  // Load-ok and active-list bits
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ldok_reg <= 1'b0;
      list0_reg <= 1'b0;
      list1_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && !en0_reg)
        list0_reg <= reg_wdata[`TLR_CTRL_LIST0]; // [RL12]
      if (wr_ctrl && !en1_reg)
        list1_reg <= reg_wdata[`TLR_CTRL_LIST1]; // [RL12]
      // Reload clears load-ok; a set in the same cycle is for the next period
      if (rl_evt)
        ldok_reg <= 1'b0; // [RL11]
      if (wr_ctrl && reg_wdata[`TLR_CTRL_LDOK])
        ldok_reg <= 1'b1;
      // Toggle even when both offsets point at one physical list
      if (swap_evt && en0_reg)
        list0_reg <= sel0; // [RL10] [RL15]
      if (swap_evt && en1_reg)
        list1_reg <= sel1; // [RL10] [RL15]
    end
  end
  // Sticky flags: hardware set wins over a write-one clear
  always @*
  begin
    stat_next = stat_reg;
    if (wr_stat)
      stat_next = stat_reg & ~reg_wdata[`TLR_ST_W-1:0];
    if (done0)
      stat_next[`TLR_ST_DONE0] = 1'b1; // [RL19]
    if (done1)
      stat_next[`TLR_ST_DONE1] = 1'b1; // [RL19]
    if (te0)
      stat_next[`TLR_ST_TE0] = 1'b1; // [RL6]
    if (te1)
      stat_next[`TLR_ST_TE1] = 1'b1; // [RL6]
    if (ro_evt)
      stat_next[`TLR_ST_RO] = 1'b1; // [RL13]
  end
  // Memory arbiter: generator 0 first, one fetch outstanding
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_reg <= 5'h00;
      owner_reg <= 1'b0;
      busy_reg <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= 24'h000000;
    end
    else
    begin
      stat_reg <= stat_next;
      if (busy_reg)
      begin
        if (mem_ack || rl_evt)
        begin
          busy_reg <= 1'b0;
          mem_req <= 1'b0;
        end
      end
      else if (req0 && !rl_evt)
      begin
        busy_reg <= 1'b1;
        owner_reg <= 1'b0;
        mem_req <= 1'b1;
        mem_addr <= {base_reg[`TLR_ADR_W-1:`TLR_WIN_W], addr0}; // [RL7]
      end
      else if (req1 && !rl_evt)
      begin
        busy_reg <= 1'b1;
        owner_reg <= 1'b1;
        mem_req <= 1'b1;
        mem_addr <= {base_reg[`TLR_ADR_W-1:`TLR_WIN_W], addr1}; // [RL7]
      end
    end
  end
  // Registered outputs and read port
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gen0_trigger <= 1'b0;
      gen1_trigger <= 1'b0;
      load_ok <= 1'b0;
      gen0_done_flag <= 1'b0;
      gen1_done_flag <= 1'b0;
      timing_error_flag <= 1'b0;
      reload_overrun_flag <= 1'b0;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      gen0_trigger <= trig0;
      gen1_trigger <= trig1;
      load_ok <= ldok_reg; // [RL14]
      gen0_done_flag <= stat_reg[`TLR_ST_DONE0];
      gen1_done_flag <= stat_reg[`TLR_ST_DONE1];
      timing_error_flag <= stat_reg[`TLR_ST_TE0] | stat_reg[`TLR_ST_TE1];
      reload_overrun_flag <= stat_reg[`TLR_ST_RO];
      reg_rdata <= rdata_next;
    end
  end
  // Read mux; data stands only in the cycle after the strobe
  always @*
  begin
    rdata_next = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        `TLR_REG_CTRL:
          rdata_next = {27'h0000000, list1_reg, list0_reg, ldok_reg, en1_reg, en0_reg};
        `TLR_REG_BASE:
          rdata_next = {8'h00, base_reg};
        `TLR_REG_G0L0:
          rdata_next = {24'h000000, g0l0_reg};
        `TLR_REG_G0L1:
          rdata_next = {24'h000000, g0l1_reg};
        `TLR_REG_G1L0:
          rdata_next = {24'h000000, g1l0_reg};
        `TLR_REG_G1L1:
          rdata_next = {24'h000000, g1l1_reg};
        `TLR_REG_STAT:
          rdata_next = {27'h0000000, stat_reg};
        default:
          rdata_next = 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tlr_top_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module tlr_top_props (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Reload and memory
  input wire logic reload,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic mem_ack,
  // Flags
  input wire logic load_ok,
  input wire logic gen0_done_flag,
  input wire logic reload_overrun_flag
);
  logic [1:0] en_reg;
  logic [23:0] base_reg;
  wire ctl_wr = reg_wr && reg_addr == 4'h0;
  wire clr0 = reg_wr && reg_addr == 4'h6 && reg_wdata[0];
  // Shadow of the enables and of the accepted base pointer
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      en_reg <= 2'h0;
      base_reg <= 24'h0;
    end
    else
    begin
      if (ctl_wr)
        en_reg <= reg_wdata[1:0];
      if (reg_wr && reg_addr == 4'h1 && en_reg == 2'h0)
        base_reg <= reg_wdata[23:0];
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_base_readback: assert property (reg_rd && reg_addr == 4'h1 |=>
    reg_rdata[23:0] == base_reg) else $error("base pointer readback wrong");
  a_fetch_window: assert property (mem_req |-> mem_addr[23:8] == base_reg[23:8])
    else $error("fetch outside window");
  a_ldok_clear: assert property (reload && !(ctl_wr && reg_wdata[2]) |-> ##2 !load_ok)
    else $error("load ok not cleared by reload");
  a_ldok_set: assert property (ctl_wr && reg_wdata[2] |-> ##2 load_ok)
    else $error("load ok not exported");
  a_overrun_set: assert property (reload && !ctl_wr && en_reg != 2'h0 ##1 !load_ok
    |-> ##1 reload_overrun_flag) else $error("overrun flag missing");
  a_done_sticky: assert property (gen0_done_flag && !$past(clr0) |=> gen0_done_flag)
    else $error("done flag lost");
  a_req_hold: assert property (mem_req && !mem_ack && !reload && !$past(reload) |=>
    mem_req && $stable(mem_addr)) else $error("fetch request not held");
  a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("fetch request not dropped");
endmodule
bind tlr_top tlr_top_props i_props (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reload, .mem_req, .mem_addr, .mem_ack, .load_ok, .gen0_done_flag,
  .reload_overrun_flag);
`default_nettype wire

// ==== tlr_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module tlr_mem_model (
  // Clock
  input wire logic clk,
  // Fetch port
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_data
);
  logic [15:0] words [0:127];
  int lat = 0;
  int wait_cnt = 0;
  initial
  begin
    mem_ack = 1'b0;
    mem_data = 16'h0;
  end
  // Data toggles outside the answer cycle so stale values never look valid
  always @(posedge clk)
    if (mem_req && !mem_ack && wait_cnt >= lat)
    begin
      mem_ack <= 1'b1;
      mem_data <= words[mem_addr[7:1]];
      wait_cnt <= 0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_data <= ~mem_data;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 1 : 0;
    end
endmodule
`default_nettype wire

// ==== test_trigger_list_reload.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_trigger_list_reload;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reload = 1'b0;
  logic async_q = 1'b0;
  wire [31:0] reg_rdata;
  wire mem_req, mem_ack, gen0_trigger, gen1_trigger, load_ok;
  wire gen0_done_flag, gen1_done_flag, timing_error_flag, reload_overrun_flag;
  wire [23:0] mem_addr;
  wire [15:0] mem_data;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n0 = 0;
  int n1 = 0;
  int t0 [0:3];
  always #50 clk = ~clk;
  tlr_top i_dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reload,
    .async_reload_qualifier(async_q), .mem_req, .mem_addr, .mem_ack, .mem_data,
    .gen0_trigger, .gen1_trigger, .load_ok, .gen0_done_flag, .gen1_done_flag,
    .timing_error_flag, .reload_overrun_flag);
  tlr_mem_model i_mem (.clk, .mem_req, .mem_addr, .mem_ack, .mem_data);
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (gen0_trigger === 1'b1)
    begin
      if (n0 < 4)
        t0[n0] <= cyc;
      n0 <= n0 + 1;
    end
    if (gen1_trigger === 1'b1)
      n1 <= n1 + 1;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, reg_rdata, exp);
  endtask
  // Clears status, sets load-ok if asked, pulses reload and lets both lists run out
  task automatic fire(input logic ok, input logic a, input int lt);
    wr(4'h6, 32'h1f);
    wr(4'h0, ok ? 32'h07 : 32'h03);
    i_mem.lat = lt;
    @(negedge clk);
    n0 = 0;
    n1 = 0;
    @(posedge clk);
    reload <= 1'b1;
    async_q <= a;
    @(posedge clk);
    reload <= 1'b0;
    async_q <= 1'b0;
    repeat (150) @(posedge clk);
  endtask
  task automatic t_regs();
    logic [7:0] ofs [0:3];
    ofs = '{8'h00, 8'h20, 8'h40, 8'h40};
    rd(4'h6, 32'h0, "status");
    wr(4'h1, 32'h00123456);
    for (int i = 0; i < 4; i++)
      wr(4'h2 + i[3:0], {24'h0, ofs[i]});
    wr(4'h9, 32'hff);
    rd(4'h9, 32'h0, "unmapped");
    rd(4'h0, 32'h0, "ctrl");
    wr(4'h0, 32'h01);
    wr(4'h1, 32'h00abcd00);
    rd(4'h1, 32'h00123456, "base");
    wr(4'h2, 32'h10);
    rd(4'h2, 32'h0, "gen0 offset");
    wr(4'h4, 32'h44);
    rd(4'h4, 32'h44, "gen1 offset");
    wr(4'h4, 32'h40);
    wr(4'h0, 32'h19);
    rd(4'h0, 32'h11, "list bits");
    wr(4'h0, 32'h03);
    $display("registers and locks done");
  endtask
  task automatic t_lists();
    i_mem.words[0] = 16'd30;
    i_mem.words[1] = 16'd45;
    i_mem.words[2] = 16'd0;
    i_mem.words[16] = 16'd20;
    i_mem.words[17] = 16'd40;
    i_mem.words[18] = 16'd0;
    i_mem.words[32] = 16'd60;
    i_mem.words[33] = 16'd0;
    fire(1'b1, 1'b0, 0);
    chk("gen0 count", n0, 2);
    chk("gen0 spacing", t0[1] - t0[0], 20);
    chk("gen1 count", n1, 1);
    chk("gen1 done", gen1_done_flag, 1'b1);
    chk("load ok low", load_ok, 1'b0);
    rd(4'h0, 32'h1b, "swap");
    rd(4'h6, 32'h03, "done");
    fire(1'b0, 1'b1, 3);
    chk("gen0 count", n0, 2);
    chk("kept spacing", t0[1] - t0[0], 20);
    rd(4'h0, 32'h1b, "kept lists");
    chk("overrun", reload_overrun_flag, 1'b1);
    fire(1'b1, 1'b0, 2);
    chk("list0 spacing", t0[1] - t0[0], 15);
    rd(4'h0, 32'h03, "swap back");
    $display("list swapping done");
  endtask
  task automatic t_error();
    i_mem.words[16] = 16'd30;
    i_mem.words[17] = 16'd12;
    fire(1'b1, 1'b0, 1);
    chk("halted count", n0, 1);
    rd(4'h6, 32'h06, "timing status");
    chk("timing flag", timing_error_flag, 1'b1);
    $display("timing error done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_lists();
    t_error();
    tally_and_finish();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
